// file: op4_defines.svh
// Constants for the fourth sequenced output dependency block
// Assumes a single synchronous clock domain and byte-wide register access
//
// Functional notes
// [R1] Term-1 first register: detector primaries, two watchdogs
// [R2] Term-1 second register: detector secondaries, logic inputs 1-2
// [R3] Term-1 third register: inputs 3-4, outputs; shared bit0
// [R4] Term-2 uses 0x20-0x22 and shared bit1
// [R5] Cleared select bit makes source irrelevant
// [R6] Output deasserts when either term is one
// [R7] Manual-reset select bit3 asserts output while low
// [R8] Small variant host writes unused select bits zero
// [R9] Term is AND of selected good states
`ifndef OP4_DEFINES_SVH
`define OP4_DEFINES_SVH

`define OP4_ADDR_T1_DET_WD  8'h1d
`define OP4_ADDR_T1_SEC_GPI 8'h1e
`define OP4_ADDR_T1_GPI_OUT 8'h1f
`define OP4_ADDR_T2_DET_WD  8'h20
`define OP4_ADDR_T2_SEC_GPI 8'h21
`define OP4_ADDR_T2_GPI_OUT 8'h22
`define OP4_ADDR_OUT8_SEL   8'h23
`define OP4_ADDR_MR_SEL     8'h40

`define OP4_BIT_OUT8_T1     0
`define OP4_BIT_OUT8_T2     1
`define OP4_BIT_MR_SEL      3

// Bit positions of each source group in the term vectors
`define OP4_TERM_WIDTH      25
`define OP4_POS_PRIMARY     0
`define OP4_POS_WATCHDOG    6
`define OP4_POS_SECONDARY   8
`define OP4_POS_GPI_LOW     14
`define OP4_POS_GPI_HIGH    16
`define OP4_POS_OUTPUTS     18
`define OP4_POS_OUT8        24

// Terms reset high, output resets asserted so loads stay held off
`define OP4_TERM_RESET      1'b1
`define OP4_OUT_RESET       1'b1

`define OP4_REG_RESET       8'h00
`define OP4_REG_COUNT       8
`define OP4_UNMAPPED_DATA   8'h00

`endif

// file: op4_pkg.sv
// Types shared by the fourth sequenced output dependency block
// Assumes op4_defines.svh supplies the numeric constants
package op4_pkg;

  // Good-state of every selectable source, one means healthy
  typedef struct packed {
    logic [5:0] detector_primary_ok;
    logic [5:0] detector_secondary_ok;
    logic [1:0] watchdog_ok;
    logic [3:0] logic_input;
    logic       output_eight_ok;
    logic [5:0] other_output_ok;
  } op4_src_s;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       write;
  } op4_req_s;

  typedef enum logic [3:0] {
    OP4_IDX_T1_DET_WD  = 4'h0,
    OP4_IDX_T1_SEC_GPI = 4'h1,
    OP4_IDX_T1_GPI_OUT = 4'h2,
    OP4_IDX_T2_DET_WD  = 4'h3,
    OP4_IDX_T2_SEC_GPI = 4'h4,
    OP4_IDX_T2_GPI_OUT = 4'h5,
    OP4_IDX_OUT8_SEL   = 4'h6,
    OP4_IDX_MR_SEL     = 4'h7,
    OP4_IDX_NONE       = 4'hf
  } op4_idx_e;

endpackage : op4_pkg

// file: op4_term.sv
// One product term: AND of the good states of the selected sources
// Assumes select and source vectors share one bit order
`timescale 1ns/1ns
`include "op4_defines.svh"
module op4_term #(
  parameter int WIDTH = 25
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // Term inputs
  input  wire logic [WIDTH-1:0] select_in,
  input  wire logic [WIDTH-1:0] good_in,
  // Term value
  output logic                  term_out
);

  logic next_term;

  always_comb
  begin
    // Unselected bits are forced to one, so an empty term reads one
    next_term = &(good_in | ~select_in); // see [R5] see [R9]
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      term_out <= `OP4_TERM_RESET;
    else
      term_out <= next_term;
  end

endmodule : op4_term

// file: op4_regs.sv
// Small register file for the selection masks, registered read data
// Assumes the caller decodes the address into an index
`timescale 1ns/1ns
`include "op4_defines.svh"
module op4_regs #(
  parameter int COUNT = `OP4_REG_COUNT
) (
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    resetn_in,
  // Access port
  input  wire logic                    write_in,
  input  wire logic                    hit_in,
  input  wire logic [3:0]              index_in,
  input  wire logic [7:0]              wdata_in,
  // Contents and read data
  output logic      [COUNT-1:0][7:0]   contents_out,
  output logic      [7:0]              rdata_out
);

  logic [COUNT-1:0][7:0] next_contents;
  logic [7:0]            next_rdata;

  always_comb
  begin
    next_contents = contents_out;
    next_rdata    = `OP4_UNMAPPED_DATA;
    if (hit_in)
    begin
      next_rdata = contents_out[index_in[2:0]];
      if (write_in)
        next_contents[index_in[2:0]] = wdata_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      contents_out <= {COUNT{`OP4_REG_RESET}};
      rdata_out    <= `OP4_UNMAPPED_DATA;
    end
    else
    begin
      contents_out <= next_contents;
      rdata_out    <= next_rdata;
    end
  end

endmodule : op4_regs

// file: op4_top.sv
// Dependency logic of the fourth sequenced output
// Assumes source pins are asynchronous; register port is on clk_in
`timescale 1ns/1ns
`include "op4_defines.svh"
module op4_top (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // Register port
  input  op4_pkg::op4_req_s     req_in,
  output logic      [7:0]       rdata_out,
  // Source pins
  input  op4_pkg::op4_src_s     src_in,
  input  wire logic             manual_reset_n_in,
  // Output and its causes
  output logic                  sequenced_output_four_out,
  output logic                  term1_out,
  output logic                  term2_out
);
  import op4_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for every pin
  // Only the second stage is read; the price is two cycles of pin latency
  op4_src_s src_meta;
  op4_src_s src_sync;
  op4_src_s next_src_meta;
  op4_src_s next_src_sync;
  logic     mr_n_meta;
  logic     mr_n_sync;
  logic     next_mr_n_meta;
  logic     next_mr_n_sync;

  always_comb
  begin
    next_src_meta  = src_in;
    next_src_sync  = src_meta;
    next_mr_n_meta = manual_reset_n_in;
    next_mr_n_sync = mr_n_meta;
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      src_meta  <= '1;
      src_sync  <= '1;
      mr_n_meta <= 1'b1;
      mr_n_sync <= 1'b1;
    end
    else
    begin
      src_meta  <= next_src_meta;
      src_sync  <= next_src_sync;
      mr_n_meta <= next_mr_n_meta;
      mr_n_sync <= next_mr_n_sync;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Address decode
  op4_idx_e        index;
  logic            hit;
  logic [7:0][7:0] regs;

  always_comb
  begin
    case (req_in.addr)
      `OP4_ADDR_T1_DET_WD:  index = OP4_IDX_T1_DET_WD;
      `OP4_ADDR_T1_SEC_GPI: index = OP4_IDX_T1_SEC_GPI;
      `OP4_ADDR_T1_GPI_OUT: index = OP4_IDX_T1_GPI_OUT;
      `OP4_ADDR_T2_DET_WD:  index = OP4_IDX_T2_DET_WD;
      `OP4_ADDR_T2_SEC_GPI: index = OP4_IDX_T2_SEC_GPI;
      `OP4_ADDR_T2_GPI_OUT: index = OP4_IDX_T2_GPI_OUT;
      `OP4_ADDR_OUT8_SEL:   index = OP4_IDX_OUT8_SEL;
      `OP4_ADDR_MR_SEL:     index = OP4_IDX_MR_SEL;
      default:              index = OP4_IDX_NONE;
    endcase
    hit = (index != OP4_IDX_NONE);
  end

  // Unused select bits on the small variant are the host's to keep zero
  op4_regs #(
    .COUNT (`OP4_REG_COUNT)
  ) u_regs (
    .clk_in       (clk_in),
    .resetn_in    (resetn_in),
    .write_in     (req_in.write),
    .hit_in       (hit),
    .index_in     (index),
    .wdata_in     (req_in.wdata),
    .contents_out (regs),
    .rdata_out    (rdata_out)
  );

  //////////////////////////////////////////////////////////////////////
  // Source vector in register bit order: first, second, third, then bit 24
  // One line per source, so the map reads straight against the masks
  logic [`OP4_TERM_WIDTH-1:0] good;
  logic [`OP4_TERM_WIDTH-1:0] sel1;
  logic [`OP4_TERM_WIDTH-1:0] sel2;

  always_comb
  begin
    // Primary detector results, first register bits 0 to 5
    good[0]  = src_sync.detector_primary_ok[0]; // see [R1]
    good[1]  = src_sync.detector_primary_ok[1];
    good[2]  = src_sync.detector_primary_ok[2];
    good[3]  = src_sync.detector_primary_ok[3];
    good[4]  = src_sync.detector_primary_ok[4];
    good[5]  = src_sync.detector_primary_ok[5];
    // Watchdogs, first register bits 6 and 7
    good[6]  = src_sync.watchdog_ok[0]; // see [R1]
    good[7]  = src_sync.watchdog_ok[1];
    // Secondary detector results, second register bits 0 to 5
    good[8]  = src_sync.detector_secondary_ok[0]; // see [R2]
    good[9]  = src_sync.detector_secondary_ok[1];
    good[10] = src_sync.detector_secondary_ok[2];
    good[11] = src_sync.detector_secondary_ok[3];
    good[12] = src_sync.detector_secondary_ok[4];
    good[13] = src_sync.detector_secondary_ok[5];
    // Logic inputs one and two, second register bits 6 and 7
    good[14] = src_sync.logic_input[0]; // see [R2]
    good[15] = src_sync.logic_input[1];
    // Logic inputs three and four, third register bits 0 and 1
    good[16] = src_sync.logic_input[2]; // see [R3]
    good[17] = src_sync.logic_input[3];
    // Other outputs in order, third register bits 2 to 7
    good[18] = src_sync.other_output_ok[0]; // see [R3]
    good[19] = src_sync.other_output_ok[1];
    good[20] = src_sync.other_output_ok[2];
    good[21] = src_sync.other_output_ok[3];
    good[22] = src_sync.other_output_ok[4];
    good[23] = src_sync.other_output_ok[5];
    // Output eight, selected from the shared register
    good[24] = src_sync.output_eight_ok; // see [R3]
  end

  always_comb
  begin
    // Term one: detector and watchdog register
    sel1[`OP4_POS_PRIMARY+:6]   = regs[OP4_IDX_T1_DET_WD][5:0]; // see [R1]
    sel1[`OP4_POS_WATCHDOG+:2]  = regs[OP4_IDX_T1_DET_WD][7:6]; // see [R1]
    // Secondary detector and logic input register
    sel1[`OP4_POS_SECONDARY+:6] = regs[OP4_IDX_T1_SEC_GPI][5:0]; // see [R2]
    sel1[`OP4_POS_GPI_LOW+:2]   = regs[OP4_IDX_T1_SEC_GPI][7:6]; // see [R2]
    // Logic input and output register, output eight from the shared one
    sel1[`OP4_POS_GPI_HIGH+:2]  = regs[OP4_IDX_T1_GPI_OUT][1:0]; // see [R3]
    sel1[`OP4_POS_OUTPUTS+:6]   = regs[OP4_IDX_T1_GPI_OUT][7:2]; // see [R3]
    sel1[`OP4_POS_OUT8]         = regs[OP4_IDX_OUT8_SEL][`OP4_BIT_OUT8_T1]; // see [R3]
  end

  always_comb
  begin
    // Term two: same layout, shared register bit 1 for output eight
    sel2[`OP4_POS_PRIMARY+:6]   = regs[OP4_IDX_T2_DET_WD][5:0]; // see [R4]
    sel2[`OP4_POS_WATCHDOG+:2]  = regs[OP4_IDX_T2_DET_WD][7:6];
    sel2[`OP4_POS_SECONDARY+:6] = regs[OP4_IDX_T2_SEC_GPI][5:0];
    sel2[`OP4_POS_GPI_LOW+:2]   = regs[OP4_IDX_T2_SEC_GPI][7:6];
    sel2[`OP4_POS_GPI_HIGH+:2]  = regs[OP4_IDX_T2_GPI_OUT][1:0];
    sel2[`OP4_POS_OUTPUTS+:6]   = regs[OP4_IDX_T2_GPI_OUT][7:2];
    sel2[`OP4_POS_OUT8]         = regs[OP4_IDX_OUT8_SEL][`OP4_BIT_OUT8_T2]; // see [R4]
  end

  op4_term #(
    .WIDTH (`OP4_TERM_WIDTH)
  ) u_term1 (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .select_in (sel1),
    .good_in   (good),
    .term_out  (term1_out)
  );

  op4_term #(
    .WIDTH (`OP4_TERM_WIDTH)
  ) u_term2 (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .select_in (sel2),
    .good_in   (good),
    .term_out  (term2_out)
  );

  //////////////////////////////////////////////////////////////////////
  // Output: manual reset overrides the terms, since it is a forced assert
  logic next_out;
  logic mr_assert;

  always_comb
  begin
    mr_assert = regs[OP4_IDX_MR_SEL][`OP4_BIT_MR_SEL] & ~mr_n_sync; // see [R7]
    next_out  = ~(term1_out | term2_out); // see [R6]
    if (mr_assert)
      next_out = 1'b1; // see [R7]
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      sequenced_output_four_out <= `OP4_OUT_RESET;
    else
      sequenced_output_four_out <= next_out;
  end

endmodule : op4_top

// file: op4_load_model.sv
// Model of the supply enable input driven by the sequenced output
// Assumes a level on clk_in, 1 = asserted
`timescale 1ns/1ns
module op4_load_model (
  // Clock and level
  input  wire logic       clk_in,
  input  wire logic       level_in,
  // Assertions seen so far
  output logic      [7:0] count_out
);
  logic prev = 1'b0;
  initial count_out = 8'h00;
  // Counts rising levels only, so a held assertion counts once
  always @(posedge clk_in)
  begin
    prev <= level_in;
    if (level_in && !prev)
      count_out <= count_out + 8'h01;
  end
endmodule : op4_load_model

// file: op4_properties.sv
// Checker of the output dependency block
// Assumes it is bound to op4_top and sees only its ports
`timescale 1ns/1ns
module op4_properties (
  // Clock, reset and register port
  input wire logic         clk_in,
  input wire logic         resetn_in,
  input op4_pkg::op4_req_s req_in,
  input wire logic [7:0]   rdata_out,
  // Sources and results
  input op4_pkg::op4_src_s src_in,
  input wire logic         manual_reset_n_in,
  input wire logic         sequenced_output_four_out,
  input wire logic         term1_out,
  input wire logic         term2_out
);
  import op4_pkg::*;
  logic [7:0]  sh [128];
  logic [7:0]  rd_exp;
  logic [24:0] g;
  logic [24:0] s1;
  logic [24:0] s2;
  logic        map;
  logic        mr_sel;
  assign g = {src_in.output_eight_ok, src_in.other_output_ok, src_in.logic_input,
    src_in.detector_secondary_ok, src_in.watchdog_ok, src_in.detector_primary_ok};
  assign s1 = {sh[7'h23][0], sh[7'h1f], sh[7'h1e], sh[7'h1d]};
  assign s2 = {sh[7'h23][1], sh[7'h22], sh[7'h21], sh[7'h20]};
  assign mr_sel = sh[7'h40][3];
  assign map = (req_in.addr >= 8'h1d && req_in.addr <= 8'h23) || req_in.addr == 8'h40;
  // Shadow of the masks, kept from the register port alone
  always_ff @(posedge clk_in)
  begin
    rd_exp <= (map && resetn_in) ? sh[req_in.addr[6:0]] : 8'h00;
    if (!resetn_in)
      sh <= '{default: 8'h00};
    else if (req_in.write && map)
      sh[req_in.addr[6:0]] <= req_in.wdata;
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  a_read_back: assert property (rdata_out == rd_exp)
    else $error("bad read data");
  a_term1_value: assert property (($stable(g) && $stable(s1))[*3] |=>
    term1_out == $past(&(g | ~s1))) else $error("bad term1");
  a_term2_value: assert property (($stable(g) && $stable(s2))[*3] |=>
    term2_out == $past(&(g | ~s2))) else $error("bad term2");
  a_term1_empty: assert property ((s1 == 25'h0)[*2] |=> term1_out)
    else $error("empty term1 low");
  a_term2_empty: assert property ((s2 == 25'h0)[*2] |=> term2_out)
    else $error("empty term2 low");
  a_out_follows: assert property (manual_reset_n_in[*3] |=>
    sequenced_output_four_out == !($past(term1_out) || $past(term2_out)))
    else $error("bad output");
  a_mr_asserts: assert property ((mr_sel && !manual_reset_n_in)[*3] |=>
    sequenced_output_four_out) else $error("no manual assert");
  a_mr_unselected: assert property ((!mr_sel)[*2] |=>
    sequenced_output_four_out == !($past(term1_out) || $past(term2_out)))
    else $error("manual leak");
endmodule : op4_properties
bind op4_top op4_properties u_prop (.*);

// file: op4_top_tb_top.sv
// Bench for the output dependency block
// Assumes op4_top, its checker and op4_load_model are compiled first
`timescale 1ns/1ns
module op4_top_tb_top;
  import op4_pkg::*;
  localparam logic [7:0] ADR [8] = '{8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h40};
  logic       clk_in = 0;
  logic       resetn_in = 0;
  logic       manual_reset_n_in = 1;
  logic       sequenced_output_four_out, term1_out, term2_out;
  logic [7:0] rdata_out, cnt, c0;
  op4_req_s   req_in = '0;
  op4_src_s   src_in = '1;
  int         fail_count = 0, cmp_count = 0, cyc = 0;
  always #50 clk_in = ~clk_in;
  op4_top uut (.*);
  op4_load_model load (.clk_in(clk_in), .level_in(sequenced_output_four_out), .count_out(cnt));
  ////////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  task chk(string n, logic [7:0] e, logic [7:0] v);
    cmp_count++;
    if (v !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, v);
    end
  endtask : chk
  task wr(logic [7:0] a, logic [7:0] d);
    req_in = '{a, d, 1'b1};
    @(negedge clk_in);
    req_in.write = 0;
    @(negedge clk_in);
  endtask : wr
  task rd(logic [7:0] a, logic [7:0] e);
    req_in.addr = a;
    @(negedge clk_in);
    chk("rdata", e, rdata_out);
  endtask : rd
  // Four edges covers both the pin path and the mask path
  task settle;
    repeat (4) @(negedge clk_in);
  endtask : settle
  task masks(logic [24:0] m1, logic [24:0] m2);
    for (int k = 0; k < 3; k++) wr(8'(29 + k), m1[8*k+:8]);
    for (int k = 0; k < 3; k++) wr(8'(32 + k), m2[8*k+:8]);
    wr(8'h23, {6'h00, m2[24], m1[24]});
  endtask : masks
  function automatic op4_src_s to_src(logic [24:0] v);
    to_src = '{v[5:0], v[13:8], v[7:6], v[17:14], v[24], v[23:18]};
  endfunction : to_src
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    foreach (ADR[k]) rd(ADR[k], 8'h00);
    chk("term1", 8'h01, {7'h0, term1_out});
    chk("term2", 8'h01, {7'h0, term2_out});
    chk("out", 8'h00, {7'h0, sequenced_output_four_out});
    foreach (ADR[k]) wr(ADR[k], 8'ha5 ^ 8'(k));
    wr(8'h41, 8'hff);
    foreach (ADR[k]) rd(ADR[k], 8'ha5 ^ 8'(k));
    rd(8'h41, 8'h00);
    $display("t_regs done");
  endtask : t_regs
  // Each source alone in both terms, then in one term only
  task t_src;
    for (int i = 0; i < 25; i++)
    begin
      masks(25'h1 << i, 25'h1 << i);
      src_in = to_src(~(25'h1 << i));
      settle;
      chk("term1", 8'h00, {7'h0, term1_out});
      chk("term2", 8'h00, {7'h0, term2_out});
      chk("out", 8'h01, {7'h0, sequenced_output_four_out});
      masks(i[0] ? 25'h0 : 25'h1 << i, i[0] ? 25'h1 << i : 25'h0);
      settle;
      chk("term1", {7'h0, i[0]}, {7'h0, term1_out});
      chk("term2", {7'h0, ~i[0]}, {7'h0, term2_out});
      chk("out", 8'h00, {7'h0, sequenced_output_four_out});
      src_in = '1;
    end
    $display("t_src done");
  endtask : t_src
  // Small-variant host: detectors five, six and outputs one, two, eight left clear
  task t_small;
    masks(25'h0f3cfcf, 25'h0f3cfcf);
    src_in = to_src(25'h0f3cfcf);
    settle;
    chk("out", 8'h00, {7'h0, sequenced_output_four_out});
    src_in = to_src(25'h0f3cfce);
    settle;
    chk("out", 8'h01, {7'h0, sequenced_output_four_out});
    src_in = '1;
    $display("t_small done");
  endtask : t_small
  task t_mr;
    masks(25'h0, 25'h0);
    wr(8'h40, 8'h08);
    c0 = cnt;
    manual_reset_n_in = 0;
    settle;
    chk("out", 8'h01, {7'h0, sequenced_output_four_out});
    chk("load", c0 + 8'h01, cnt);
    manual_reset_n_in = 1;
    settle;
    chk("out", 8'h00, {7'h0, sequenced_output_four_out});
    wr(8'h40, 8'hf7);
    manual_reset_n_in = 0;
    settle;
    chk("out", 8'h00, {7'h0, sequenced_output_four_out});
    manual_reset_n_in = 1;
    $display("t_mr done");
  endtask : t_mr
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      finish_test;
    end
  end
  initial
  begin
    repeat (10) @(negedge clk_in);
    resetn_in = 1;
    @(negedge clk_in);
    t_regs;
    t_src;
    t_small;
    t_mr;
    finish_test;
  end
endmodule : op4_top_tb_top
